// [shared/spi_eeprom_pkg.sv]
/*
 * Constants and carrier types for the serial EEPROM slave port.
 * Assumes one core clock domain and the serial clock as the link domain.
 */
package spi_eeprom_pkg;
    localparam int ARRAY_BYTES = 65536;
    localparam int ADDR_W      = 16;
    localparam int PAGE_BYTES  = 128;
    localparam int PAGE_COUNT  = 512;
    localparam int PAGE_W      = 7;
    localparam int ID_BYTES    = 128;
    localparam int FIFO_DEPTH  = 4;

    // Command codes
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_RDSR = 8'h05;
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_WRIT = 8'h02;
    localparam logic [7:0] OP_RDID = 8'h83;
    localparam logic [7:0] OP_WRID = 8'h82;
    localparam logic [7:0] OP_LOCK = 8'h92;

    // Status byte layout
    localparam int SR_WIP  = 0;
    localparam int SR_WEL  = 1;
    localparam int SR_BP0  = 2;
    localparam int SR_SRWD = 7;

    // Values after reset
    localparam logic       WEL_RST  = 1'b0;
    localparam logic       SRWD_RST = 1'b0;
    localparam logic [1:0] BP_RST   = 2'h0;
    localparam logic       LOCK_RST = 1'b0;

    typedef enum logic [2:0] {
        K_WEL_SET,
        K_WEL_CLR,
        K_STATUS,
        K_ARRAY,
        K_ID,
        K_LOCK
    } kind_t;

    typedef struct packed {
        kind_t             kind;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
    } wr_entry_t;
endpackage

// [hdl/spi_eeprom.sv]
/*
 * Serial EEPROM slave port: link logic on the serial clock, a dual-clock
 * write FIFO, and the core that owns the array, id page and status.
 * Assumes the master drives select, data and hold in step with the
 * serial clock; the serial clock only runs inside frames.
 */
`timescale 1ns/1ns

module spi_eeprom_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = spi_eeprom_pkg::FIFO_DEPTH
) (
    input  wire logic             i_wr_clk,
    input  wire logic             i_wr_arst,
    input  wire logic             i_wr_valid,
    output logic                  o_wr_ready,
    input  wire logic [WIDTH-1:0] i_wr_data,
    input  wire logic             i_rd_clk,
    input  wire logic             i_rd_rst,
    input  wire logic             i_rd_ce,
    output logic                  o_rd_valid,
    input  wire logic             i_rd_ready,
    output logic [WIDTH-1:0]      o_rd_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] buf_r [DEPTH];
    logic [AW:0]      wb_r;
    logic [AW:0]      wg_r;
    logic [AW:0]      rb_r;
    logic [AW:0]      rg_r;
    logic [AW:0]      rg_s1_r;
    logic [AW:0]      rg_s2_r;
    logic [AW:0]      wg_s1_r;
    logic [AW:0]      wg_s2_r;
    logic [AW:0]      wb_nxt;
    logic [AW:0]      rb_nxt;
    logic             wr_go;
    logic             rd_go;

    assign wb_nxt = wb_r + (AW+1)'(1);
    assign rb_nxt = rb_r + (AW+1)'(1);
    assign o_wr_ready = wg_r != {~rg_s2_r[AW:AW-1], rg_s2_r[AW-2:0]};
    assign o_rd_valid = rg_r != wg_s2_r;
    assign o_rd_data  = buf_r[rb_r[AW-1:0]];
    assign wr_go = i_wr_valid & o_wr_ready;
    assign rd_go = i_rd_ce & o_rd_valid & i_rd_ready;

    // Write side has no free clock, so its reset cannot be synchronous
    always_ff @(posedge i_wr_clk or posedge i_wr_arst) begin
        if (i_wr_arst) begin
            wb_r <= '0;
            wg_r <= '0;
        end else if (wr_go) begin
            wb_r <= wb_nxt;
            wg_r <= wb_nxt ^ (wb_nxt >> 1);
        end
    end

    // Read pointer seen late here only makes full pessimistic
    always_ff @(posedge i_wr_clk or posedge i_wr_arst) begin
        if (i_wr_arst) begin
            rg_s1_r <= '0;
            rg_s2_r <= '0;
        end else begin
            rg_s1_r <= rg_r;
            rg_s2_r <= rg_s1_r;
        end
    end

    always_ff @(posedge i_wr_clk) begin
        if (wr_go) begin
            buf_r[wb_r[AW-1:0]] <= i_wr_data;
        end
    end

    always_ff @(posedge i_rd_clk) begin
        if (i_rd_rst) begin
            rb_r <= '0;
            rg_r <= '0;
        end else if (rd_go) begin
            rb_r <= rb_nxt;
            rg_r <= rb_nxt ^ (rb_nxt >> 1);
        end
    end

    always_ff @(posedge i_rd_clk) begin
        if (i_rd_rst) begin
            wg_s1_r <= '0;
            wg_s2_r <= '0;
        end else if (i_rd_ce) begin
            wg_s1_r <= wg_r;
            wg_s2_r <= wg_s1_r;
        end
    end
endmodule // spi_eeprom_fifo

module spi_eeprom #(
    parameter logic [23:0] ID_CODE = 24'h5a_a5_3c  // Arbitrary value
) (
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_ce,
    input  wire logic i_sck,
    input  wire logic i_cs_n,
    input  wire logic i_mosi,
    input  wire logic i_hold_n,
    input  wire logic i_wp_n,
    output logic      o_miso,
    output logic      o_miso_oe_n,
    output logic      o_busy
);
    typedef enum logic [2:0] {
        ST_CMD,
        ST_ADR_HI,
        ST_ADR_LO,
        ST_DATA,
        ST_WAIT
    } st_t;

    localparam int EW = $bits(spi_eeprom_pkg::wr_entry_t);

    // Core domain
    logic [7:0] mem_r [spi_eeprom_pkg::ARRAY_BYTES];
    logic [7:0] id_r  [spi_eeprom_pkg::ID_BYTES];
    logic [1:0] cs_sync_r;
    logic [1:0] wp_sync_r;
    logic       armed_r;
    logic       wel_r;
    logic       srwd_r;
    logic [1:0] bp_r;
    logic       lock_r;
    logic       busy_r;
    logic       rd_valid;
    logic       pop;
    logic       arr_we;
    logic       id_we;
    logic       sr_we;
    logic [7:0] status;
    spi_eeprom_pkg::wr_entry_t rd_ent;

    // Link domain
    logic       sel_ok_r;
    st_t        st_r;
    logic [2:0] bit_cnt_r;
    logic [6:0] sh_r;
    logic [7:0] op_r;
    logic [15:0] addr_r;
    logic       rd_active_r;
    logic [7:0] rd_byte_r;
    logic [7:0] sr_s1_r;
    logic [7:0] sr_s2_r;
    logic       drv_r;
    logic       miso_r;
    logic       take;
    logic       last;
    logic [7:0] byte_in;
    logic [15:0] addr_inc;
    logic [15:0] page_inc;
    logic       push;
    logic       wr_ready;
    spi_eeprom_pkg::wr_entry_t ent;

    spi_eeprom_fifo #(
        .WIDTH (EW),
        .DEPTH (spi_eeprom_pkg::FIFO_DEPTH)
    ) u_fifo (
        .i_wr_clk   (i_sck),
        .i_wr_arst  (i_rst),
        .i_wr_valid (push),
        .o_wr_ready (wr_ready),
        .i_wr_data  (ent),
        .i_rd_clk   (i_clk),
        .i_rd_rst   (i_rst),
        .i_rd_ce    (i_ce),
        .o_rd_valid (rd_valid),
        .i_rd_ready (1'b1),
        .o_rd_data  (rd_ent)
    );

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cs_sync_r <= '0;
            wp_sync_r <= '0;
        end else if (i_ce) begin
            cs_sync_r <= {cs_sync_r[0], i_cs_n};
            wp_sync_r <= {wp_sync_r[0], i_wp_n};
        end
    end

    // Select must be seen high once before any frame counts
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            armed_r <= 1'b0;
        end else if (i_ce && cs_sync_r[1]) begin
            armed_r <= 1'b1;
        end
    end

    assign pop    = i_ce & rd_valid;
    assign arr_we = pop & (rd_ent.kind == spi_eeprom_pkg::K_ARRAY) & wel_r;
    assign id_we  = pop & (rd_ent.kind == spi_eeprom_pkg::K_ID) & wel_r
                    & ~lock_r;
    assign sr_we  = pop & (rd_ent.kind == spi_eeprom_pkg::K_STATUS) & wel_r
                    & (~srwd_r | wp_sync_r[1]);

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wel_r  <= spi_eeprom_pkg::WEL_RST;
            srwd_r <= spi_eeprom_pkg::SRWD_RST;
            bp_r   <= spi_eeprom_pkg::BP_RST;
            lock_r <= spi_eeprom_pkg::LOCK_RST;
        end else if (pop) begin
            case (rd_ent.kind)
                spi_eeprom_pkg::K_WEL_SET: wel_r <= 1'b1;
                spi_eeprom_pkg::K_WEL_CLR: wel_r <= 1'b0;
                spi_eeprom_pkg::K_STATUS: begin
                    if (sr_we) begin
                        srwd_r <= rd_ent.data[spi_eeprom_pkg::SR_SRWD];
                        bp_r <= rd_ent.data[spi_eeprom_pkg::SR_BP0 +: 2];
                    end
                    wel_r <= 1'b0;
                end
                spi_eeprom_pkg::K_LOCK: begin
                    if (wel_r) begin
                        lock_r <= 1'b1;
                    end
                    wel_r <= 1'b0;
                end
                default: wel_r <= wel_r;
            endcase
        end
    end

    // Array holds stored data, so it has no reset
    always_ff @(posedge i_clk) begin
        if (arr_we) begin
            mem_r[rd_ent.addr] <= rd_ent.data;
        end
    end

    // Reset loads the delivery contents of the id page
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            for (int i = 0; i < spi_eeprom_pkg::ID_BYTES; i++) begin
                id_r[i] <= 8'h00;
            end
            id_r[0] <= ID_CODE[23:16];
            id_r[1] <= ID_CODE[15:8];
            id_r[2] <= ID_CODE[7:0];
        end else if (id_we) begin
            id_r[rd_ent.addr[spi_eeprom_pkg::PAGE_W-1:0]] <= rd_ent.data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            busy_r <= 1'b0;
        end else if (i_ce) begin
            busy_r <= rd_valid;
        end
    end

    assign o_busy = busy_r;
    assign status = {srwd_r, 3'h0, bp_r, wel_r, rd_valid};

    // Link side: qualified once per frame on select falling
    always_ff @(negedge i_cs_n or posedge i_rst) begin
        if (i_rst) begin
            sel_ok_r <= 1'b0;
        end else begin
            sel_ok_r <= armed_r;
        end
    end

    // Status is quasi-static between frames; eight edges pass before use
    always_ff @(posedge i_sck or posedge i_rst) begin
        if (i_rst) begin
            sr_s1_r <= '0;
            sr_s2_r <= '0;
        end else begin
            sr_s1_r <= status;
            sr_s2_r <= sr_s1_r;
        end
    end

    assign take     = sel_ok_r & i_hold_n;
    assign last     = bit_cnt_r == 3'h7;
    assign byte_in  = {sh_r, i_mosi};
    assign addr_inc = addr_r + 16'h1;
    assign page_inc = {addr_r[15:7], addr_r[6:0] + 7'h1};

    // Entries are pushed on the very edge that completes a byte,
    // since the clock may stop right after it
    always_comb begin
        ent      = '0;
        ent.addr = addr_r;
        ent.data = byte_in;
        push     = 1'b0;
        if (take && last && wr_ready) begin
            if (st_r == ST_CMD && byte_in == spi_eeprom_pkg::OP_WREN) begin
                ent.kind = spi_eeprom_pkg::K_WEL_SET;
                push = 1'b1;
            end else if (st_r == ST_CMD
                         && byte_in == spi_eeprom_pkg::OP_WRDI) begin
                ent.kind = spi_eeprom_pkg::K_WEL_CLR;
                push = 1'b1;
            end else if (st_r == ST_DATA) begin
                push = 1'b1;
                case (op_r)
                    spi_eeprom_pkg::OP_WRSR:
                        ent.kind = spi_eeprom_pkg::K_STATUS;
                    spi_eeprom_pkg::OP_WRIT:
                        ent.kind = spi_eeprom_pkg::K_ARRAY;
                    spi_eeprom_pkg::OP_WRID:
                        ent.kind = spi_eeprom_pkg::K_ID;
                    spi_eeprom_pkg::OP_LOCK:
                        ent.kind = spi_eeprom_pkg::K_LOCK;
                    default: push = 1'b0;
                endcase
            end
        end
    end

    always_ff @(posedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            bit_cnt_r <= '0;
            sh_r      <= '0;
        end else if (take) begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            sh_r      <= byte_in[6:0];
        end
    end

    always_ff @(posedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            st_r        <= ST_CMD;
            op_r        <= '0;
            addr_r      <= '0;
            rd_active_r <= 1'b0;
            rd_byte_r   <= '0;
        end else if (take && last) begin
            case (st_r)
                ST_CMD: begin
                    op_r <= byte_in;
                    case (byte_in)
                        spi_eeprom_pkg::OP_RDSR: begin
                            st_r        <= ST_DATA;
                            rd_active_r <= 1'b1;
                            rd_byte_r   <= sr_s2_r;
                        end
                        spi_eeprom_pkg::OP_READ,
                        spi_eeprom_pkg::OP_WRIT,
                        spi_eeprom_pkg::OP_RDID,
                        spi_eeprom_pkg::OP_WRID: st_r <= ST_ADR_HI;
                        spi_eeprom_pkg::OP_WRSR,
                        spi_eeprom_pkg::OP_LOCK: st_r <= ST_DATA;
                        default: st_r <= ST_WAIT;
                    endcase
                end
                ST_ADR_HI: begin
                    addr_r[15:8] <= byte_in;
                    st_r         <= ST_ADR_LO;
                end
                ST_ADR_LO: begin
                    addr_r[7:0] <= byte_in;
                    st_r        <= ST_DATA;
                    // Array read straight across; software waits on busy
                    if (op_r == spi_eeprom_pkg::OP_READ) begin
                        rd_active_r <= 1'b1;
                        rd_byte_r   <= mem_r[{addr_r[15:8], byte_in}];
                    end else if (op_r == spi_eeprom_pkg::OP_RDID) begin
                        rd_active_r <= 1'b1;
                        rd_byte_r   <= id_r[byte_in[6:0]];
                    end
                end
                ST_DATA: begin
                    case (op_r)
                        spi_eeprom_pkg::OP_READ: begin
                            addr_r    <= addr_inc;
                            rd_byte_r <= mem_r[addr_inc];
                        end
                        spi_eeprom_pkg::OP_RDID: begin
                            addr_r    <= page_inc;
                            rd_byte_r <= id_r[page_inc[6:0]];
                        end
                        spi_eeprom_pkg::OP_RDSR: rd_byte_r <= sr_s2_r;
                        spi_eeprom_pkg::OP_WRIT,
                        spi_eeprom_pkg::OP_WRID: addr_r <= page_inc;
                        default: st_r <= ST_WAIT;
                    endcase
                end
                default: st_r <= ST_WAIT;
            endcase
        end
    end

    // Not gated by hold: with the count frozen the bit does not change
    always_ff @(negedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            drv_r  <= 1'b0;
            miso_r <= 1'b0;
        end else begin
            drv_r  <= rd_active_r;
            miso_r <= rd_byte_r[3'h7 - bit_cnt_r];
        end
    end

    assign o_miso      = miso_r;
    assign o_miso_oe_n = ~(drv_r & ~i_cs_n & i_hold_n
                           & sel_ok_r);

    msb_out_a: assert property (
        @(posedge i_sck) disable iff (i_cs_n)
        drv_r |-> o_miso == rd_byte_r[3'h7 - bit_cnt_r])
        else $error("read bit out of order");

    idle_hiz_a: assert property (
        @(posedge i_sck) disable iff (i_cs_n)
        st_r != ST_DATA |-> o_miso_oe_n)
        else $error("output driven outside read data");

    rise_sample_a: assert property (
        @(posedge i_sck) disable iff (i_cs_n)
        take && !last |=> sh_r[0] == $past(i_mosi))
        else $error("input bit not taken on rising edge");

    deselect_hiz_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        i_cs_n |-> o_miso_oe_n)
        else $error("output driven while deselected");

    hold_pause_a: assert property (
        @(posedge i_sck) disable iff (i_cs_n)
        !i_hold_n |=> $stable(bit_cnt_r) && $stable(st_r))
        else $error("transfer moved during hold");

    wp_block_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        pop && rd_ent.kind == spi_eeprom_pkg::K_STATUS && srwd_r
        && !wp_sync_r[1] |=> $stable(bp_r) && srwd_r)
        else $error("status written while protected");

    page_wrap_a: assert property (
        @(posedge i_sck) disable iff (i_cs_n)
        take && last && st_r == ST_DATA && op_r == spi_eeprom_pkg::OP_WRIT
        && addr_r[6:0] == '1
        |=> addr_r[6:0] == '0 && $stable(addr_r[15:7]))
        else $error("page write left its page");

    lock_keep_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        lock_r |=> lock_r && !id_we)
        else $error("id page lock lost or bypassed");

    hold_hiz_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        !i_hold_n |-> o_miso_oe_n)
        else $error("output driven during hold");

    unarmed_a: assert property (
        @(posedge i_clk) disable iff (i_rst)
        !armed_r |-> o_miso_oe_n && !sel_ok_r)
        else $error("selected before select seen high");
endmodule // spi_eeprom

// [bench/spi_master_model.sv]
/*
 * Bus master model for the serial EEPROM port: mode 0 framing,
 * byte transfers, and hold pauses.
 * Assumes one bench process calls its tasks, one at a time.
 */
`timescale 1ns/1ns

module spi_master_model (
    input  wire logic i_miso,
    input  wire logic i_miso_oe_n,
    output logic      o_sck,
    output logic      o_cs_n,
    output logic      o_mosi,
    output logic      o_hold_n
);
    logic [7:0] rx_byte;
    logic       last_r;
    logic       oe_seen;
    logic       wire_q;
    event       got;

    // A released line shows the inverse of its last level, never a guess
    assign wire_q = (i_miso_oe_n === 1'b0) ? i_miso : ~last_r;

    initial begin
        o_sck    = 1'b0;
        o_cs_n   = 1'b1;
        o_mosi   = 1'b0;
        o_hold_n = 1'b1;
        last_r   = 1'b0;
        oe_seen  = 1'b0;
        rx_byte  = 8'h00;
    end

    always @(posedge o_sck) begin
        last_r <= wire_q;
        if (i_miso_oe_n === 1'b0) begin
            oe_seen <= 1'b1;
        end
    end

    task automatic start();
        o_cs_n = 1'b0;
        #10;
    endtask

    task automatic stop();
        #10;
        o_cs_n = 1'b1;
        #200;
    endtask

    task automatic xfer(input logic [7:0] tx, input bit cap);
        logic [7:0] rx;
        for (int i = 7; i >= 0; i--) begin
            o_mosi = tx[i];
            #7;
            o_sck = 1'b1;
            rx[i] = wire_q;
            #8;
            o_sck = 1'b0;
        end
        if (cap) begin
            rx_byte = rx;
            -> got;
        end
    endtask

    // Hold only starts with the clock low; noise is clocked meanwhile
    task automatic pause(input logic [7:0] bits);
        o_hold_n = 1'b0;
        for (int i = 0; i < 8; i++) begin
            o_mosi = bits[i];
            #7;
            o_sck = 1'b1;
            #8;
            o_sck = 1'b0;
        end
        #7;
        o_hold_n = 1'b1;
        #7;
    endtask
endmodule // spi_master_model

// [bench/test_spi_eeprom_serial_port.sv]
/*
 * Self-checking bench for the serial EEPROM port: id page, hold,
 * array writes, status protection, id lock and write buffer overflow.
 * Assumes the master model drives the link at a 15 ns clock period.
 */
`timescale 1ns/1ns

module test_spi_eeprom_serial_port;
    localparam logic [23:0] ID = 24'hc3_96_e1;  // Arbitrary value
    logic       i_clk;
    logic       i_rst;
    logic       i_ce;
    logic       i_wp_n;
    wire        sck;
    wire        cs_n;
    wire        mosi;
    wire        hold_n;
    logic       o_miso;
    logic       o_miso_oe_n;
    logic       o_busy;
    logic [7:0] exp_q[$];
    logic [7:0] buf_b [6];
    logic [7:0] old_b [6];
    logic [31:0] rng;
    int         mismatches;
    int         n_tests;
    int         cycles;

    spi_eeprom #(.ID_CODE(ID)) u_spi_eeprom (
        .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_sck(sck),
        .i_cs_n(cs_n), .i_mosi(mosi), .i_hold_n(hold_n),
        .i_wp_n(i_wp_n), .o_miso(o_miso), .o_miso_oe_n(o_miso_oe_n),
        .o_busy(o_busy));
    spi_master_model u_spi_master_model (
        .i_miso(o_miso), .i_miso_oe_n(o_miso_oe_n), .o_sck(sck),
        .o_cs_n(cs_n), .o_mosi(mosi), .o_hold_n(hold_n));

    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end

    function automatic logic [7:0] rnd();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng[7:0];
    endfunction

    task automatic check_byte(input string what, input logic [7:0] e,
                              input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic check_bit(input string what, input logic e,
                             input logic g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR %s expected %b seen %b", what, e, g);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Write entries cross to the core clock before they take effect
    task automatic settle();
        repeat (8) @(posedge i_clk);
        for (int i = 0; i < 200 && o_busy !== 1'b0; i++) @(posedge i_clk);
        repeat (4) @(posedge i_clk);
    endtask

    task automatic short_frame(input logic [7:0] op, input logic [7:0] b,
                               input bit has_b, input bit rd);
        u_spi_master_model.start();
        u_spi_master_model.xfer(op, 1'b0);
        if (rd) exp_q.push_back(b);
        if (has_b) u_spi_master_model.xfer(rd ? rnd() : b, rd);
        u_spi_master_model.stop();
        check_bit("oe_n after deselect", 1'b1, o_miso_oe_n);
    endtask

    task automatic frame(input logic [7:0] op, input logic [15:0] a,
                         input int n, input bit rd);
        u_spi_master_model.start();
        u_spi_master_model.xfer(op, 1'b0);
        u_spi_master_model.xfer(a[15:8], 1'b0);
        u_spi_master_model.xfer(a[7:0], 1'b0);
        for (int i = 0; i < n; i++) begin
            if (rd) exp_q.push_back(buf_b[i]);
            u_spi_master_model.xfer(rd ? rnd() : buf_b[i], rd);
        end
        u_spi_master_model.stop();
        check_bit("oe_n after deselect", 1'b1, o_miso_oe_n);
    endtask

    initial forever begin
        @(u_spi_master_model.got);
        check_byte("miso byte", exp_q.size() > 0 ? exp_q.pop_front()
                   : 8'hxx, u_spi_master_model.rx_byte);
    end

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            report_and_stop();
        end
    end

    initial begin
        i_rst = 1'b0;
        i_ce = 1'b1;
        i_wp_n = 1'b1;
        rng = 27396;
        mismatches = 0;
        n_tests = 0;
        cycles = 0;
        // A real rising edge, so the link-side async clears act
        #1 i_rst = 1'b1;
        #4 u_spi_master_model.start();
        repeat (16) @(posedge i_clk);
        #2 i_rst = 1'b0;
        // Select was never seen high: the whole frame must be ignored
        for (int i = 0; i < 4; i++) u_spi_master_model.xfer(8'h83, 1'b0);
        check_bit("oe seen unarmed", 1'b0,
                  u_spi_master_model.oe_seen);
        u_spi_master_model.stop();
        buf_b = '{ID[23:16], ID[15:8], ID[7:0], 8'h00, 8'h00, 8'h00};
        frame(spi_eeprom_pkg::OP_RDID, 16'h0000, 6, 1'b1);
        // Hold between two read bytes
        u_spi_master_model.start();
        u_spi_master_model.xfer(spi_eeprom_pkg::OP_RDID, 1'b0);
        u_spi_master_model.xfer(8'h00, 1'b0);
        u_spi_master_model.xfer(8'h01, 1'b0);
        exp_q.push_back(ID[15:8]);
        u_spi_master_model.xfer(rnd(), 1'b1);
        u_spi_master_model.oe_seen = 1'b0;
        u_spi_master_model.pause(rnd());
        check_bit("oe in hold", 1'b0,
                  u_spi_master_model.oe_seen);
        exp_q.push_back(ID[7:0]);
        u_spi_master_model.xfer(rnd(), 1'b1);
        u_spi_master_model.stop();
        // Array write that wraps inside its page
        short_frame(spi_eeprom_pkg::OP_WREN, 8'h00, 1'b0, 1'b0);
        settle();
        short_frame(spi_eeprom_pkg::OP_RDSR, 8'h02, 1'b1, 1'b1);
        buf_b[0] = rnd();
        buf_b[1] = rnd();
        frame(spi_eeprom_pkg::OP_WRIT, 16'h027f, 2, 1'b0);
        settle();
        frame(spi_eeprom_pkg::OP_READ, 16'h027f, 1, 1'b1);
        buf_b[0] = buf_b[1];
        frame(spi_eeprom_pkg::OP_READ, 16'h0200, 1, 1'b1);
        // Status write, then blocked by the protect pin
        short_frame(spi_eeprom_pkg::OP_WRSR, 8'h8c, 1'b1, 1'b0);
        settle();
        short_frame(spi_eeprom_pkg::OP_RDSR, 8'h8c, 1'b1, 1'b1);
        @(posedge i_clk) #2 i_wp_n = 1'b0;
        short_frame(spi_eeprom_pkg::OP_WREN, 8'h00, 1'b0, 1'b0);
        short_frame(spi_eeprom_pkg::OP_WRSR, 8'h00, 1'b1, 1'b0);
        short_frame(spi_eeprom_pkg::OP_WRDI, 8'h00, 1'b0, 1'b0);
        settle();
        short_frame(spi_eeprom_pkg::OP_RDSR, 8'h8c, 1'b1, 1'b1);
        @(posedge i_clk) #2 i_wp_n = 1'b1;
        short_frame(spi_eeprom_pkg::OP_WREN, 8'h00, 1'b0, 1'b0);
        short_frame(spi_eeprom_pkg::OP_WRSR, 8'h00, 1'b1, 1'b0);
        settle();
        short_frame(spi_eeprom_pkg::OP_RDSR, 8'h00, 1'b1, 1'b1);
        // Id page write, lock, refused write
        short_frame(spi_eeprom_pkg::OP_WREN, 8'h00, 1'b0, 1'b0);
        buf_b[0] = rnd();
        old_b[0] = buf_b[0];
        frame(spi_eeprom_pkg::OP_WRID, 16'h0003, 1, 1'b0);
        settle();
        frame(spi_eeprom_pkg::OP_RDID, 16'h0003, 1, 1'b1);
        short_frame(spi_eeprom_pkg::OP_LOCK, rnd(), 1'b1, 1'b0);
        settle();
        short_frame(spi_eeprom_pkg::OP_WREN, 8'h00, 1'b0, 1'b0);
        buf_b[0] = ~old_b[0];
        frame(spi_eeprom_pkg::OP_WRID, 16'h0003, 1, 1'b0);
        settle();
        buf_b[0] = old_b[0];
        frame(spi_eeprom_pkg::OP_RDID, 16'h0003, 1, 1'b1);
        // Core frozen: the write buffer fills and drops the excess
        for (int i = 0; i < 6; i++) buf_b[i] = rnd();
        frame(spi_eeprom_pkg::OP_WRIT, 16'h0400, 6, 1'b0);
        settle();
        old_b = buf_b;
        @(posedge i_clk) #2 i_ce = 1'b0;
        for (int i = 0; i < 6; i++) buf_b[i] = rnd();
        frame(spi_eeprom_pkg::OP_WRIT, 16'h0400, 6, 1'b0);
        check_bit("busy while frozen", 1'b0, o_busy);
        @(posedge i_clk) #2 i_ce = 1'b1;
        // Two sync stages, then the busy flop
        repeat (3) @(posedge i_clk);
        #2 check_bit("busy after thaw", 1'b1, o_busy);
        settle();
        buf_b[4] = old_b[4];
        buf_b[5] = old_b[5];
        frame(spi_eeprom_pkg::OP_READ, 16'h0400, 6, 1'b1);
        #100;
        check_byte("pending reads", 8'h00, 8'(exp_q.size()));
        report_and_stop();
    end
endmodule // test_spi_eeprom_serial_port
